// >>> rtl/tlic_top.sv
// two-level request controller with axi4-lite registers
// Behaviour
// - 22 sources: seventeen normal, five fast
// - fast output takes precedence over normal
// - no priority within group, all visible
// - requests are levels except latched kind
// - active and mask set asserts group output
// - status bits match mask bit positions
// - no generic clear for level sources
// - end-of-interrupt sources latch until cleared
// - first pair bits 0-3 are fast
// - first pair bits 4-11 normal sources
// - first pair bits 12-15 serial sources
// - second pair bits 0,1,2,12,13 normal
// - third pair bit 0 fast codec port
// - outputs are active-low levels
// - deglitch on 16.384 kHz derived clock
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module tlic_top
	import tlic_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// request sources
	input  wire tlic_src_type src,
	// core requests
	output tlic_core_type    core,
	// axi4-lite write address
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [4:0]  awaddr,
	// axi4-lite write data
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// axi4-lite read address
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [4:0]  araddr,
	// axi4-lite read data
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);

	// raw source vectors in register positions
	logic [15:0] raw1;
	logic [15:0] raw2;
	logic [7:0]  raw3;
	logic        pin_fast;
	logic        pin_one;
	logic        pin_two;
	logic        pin_three;
	logic        media_glitchy;

	// pin synchronisers, three stages each
	logic [2:0]  sy_fast_r, sy_one_r, sy_two_r, sy_three_r, sy_media_r;
	logic [2:0]  sy_fast_nxt, sy_one_nxt, sy_two_nxt, sy_three_nxt, sy_media_nxt;
	logic        pin_fast_r, pin_one_r, pin_two_r, pin_three_r;
	logic        pin_fast_nxt, pin_one_nxt, pin_two_nxt, pin_three_nxt;

	// deglitch filter
	logic [13:0] filt_cnt_r, filt_cnt_nxt;
	logic        filt_tick;
	logic        media_s1_r, media_s1_nxt;
	logic        media_hold_r, media_hold_nxt;
	logic        media_r, media_nxt;

	// registers
	logic [15:0] mask1_r, mask1_nxt;
	logic [15:0] mask2_r, mask2_nxt;
	logic [7:0]  mask3_r, mask3_nxt;
	logic [15:0] eoi2_r, eoi2_nxt;
	logic [15:0] stat1, stat2;
	logic [7:0]  stat3;
	logic        fast_any, norm_any;

	// bus state
	logic        aw_held_r, aw_held_nxt;
	logic        w_held_r, w_held_nxt;
	logic [4:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0]  w_strb_r, w_strb_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	logic        wr_go;
	logic        wr_hit;

	// pin changes count once stages two and three agree
	always_comb begin
		sy_fast_nxt  = {sy_fast_r[1:0], ~src.external_fast_pin_n};
		sy_one_nxt   = {sy_one_r[1:0], ~src.external_pin_one_n};
		sy_two_nxt   = {sy_two_r[1:0], ~src.external_pin_two_n};
		sy_three_nxt = {sy_three_r[1:0], src.external_request_three};
		sy_media_nxt = {sy_media_r[1:0], src.media_changed_request};
		pin_fast_nxt  = (sy_fast_r[1] == sy_fast_r[2]) ? sy_fast_r[2] : pin_fast_r;
		pin_one_nxt   = (sy_one_r[1] == sy_one_r[2]) ? sy_one_r[2] : pin_one_r;
		pin_two_nxt   = (sy_two_r[1] == sy_two_r[2]) ? sy_two_r[2] : pin_two_r;
		pin_three_nxt = (sy_three_r[1] == sy_three_r[2]) ? sy_three_r[2] : pin_three_r;
		media_glitchy = (sy_media_r[1] == sy_media_r[2]) ? sy_media_r[2] : media_hold_r;
		media_hold_nxt = media_glitchy;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy_fast_r   <= 3'h0;
			sy_one_r    <= 3'h0;
			sy_two_r    <= 3'h0;
			sy_three_r  <= 3'h0;
			sy_media_r  <= 3'h0;
			pin_fast_r  <= 1'b0;
			pin_one_r   <= 1'b0;
			pin_two_r   <= 1'b0;
			pin_three_r <= 1'b0;
			media_hold_r <= 1'b0;
		end else begin
			sy_fast_r   <= sy_fast_nxt;
			sy_one_r    <= sy_one_nxt;
			sy_two_r    <= sy_two_nxt;
			sy_three_r  <= sy_three_nxt;
			sy_media_r  <= sy_media_nxt;
			pin_fast_r  <= pin_fast_nxt;
			pin_one_r   <= pin_one_nxt;
			pin_two_r   <= pin_two_nxt;
			pin_three_r <= pin_three_nxt;
			media_hold_r <= media_hold_nxt;
		end
	end

	// media input sampled on the derived 16.384 kHz tick, held two ticks
	always_comb begin
		filt_tick    = (filt_cnt_r == FILT_LAST);
		filt_cnt_nxt = filt_tick ? 14'h0000 : filt_cnt_r + 14'h0001;
		media_s1_nxt = media_s1_r;
		media_nxt    = media_r;
		if (filt_tick) begin
			media_s1_nxt = media_glitchy;
			media_nxt    = media_glitchy & media_s1_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt_cnt_r <= 14'h0000;
			media_s1_r <= 1'b0;
			media_r    <= 1'b0;
		end else begin
			filt_cnt_r <= filt_cnt_nxt;
			media_s1_r <= media_s1_nxt;
			media_r    <= media_nxt;
		end
	end

	// source placement into status positions
	always_comb begin
		raw1 = {src.sync_one_end_transfer, src.serial_one_modem_change, src.serial_one_rx_full,
			src.serial_one_tx_empty,
			src.tick_request, src.clock_compare_match, src.timer_two_underflow, src.timer_one_underflow,
			pin_three_r, pin_two_r, pin_one_r, src.codec_sound_request,
			media_r, src.watchdog_expired_request, src.battery_low_request, pin_fast_r};
		raw2 = {2'h0, src.serial_two_rx_full, src.serial_two_tx_empty, 9'h000,
			src.sync_two_tx_block, src.sync_two_rx_block, src.key_press_request};
		raw3 = {7'h00, src.codec_port_request};
	end

	// level sources pass straight; latched kind holds until written clear
	always_comb begin
		stat1 = raw1 & (FAST1 | NORM1);
		stat2 = (raw2 & NORM2 & ~EOI2) | eoi2_r;
		stat3 = raw3 & FAST3;
		fast_any = |(stat1 & mask1_r & FAST1) | |(stat3 & mask3_r & FAST3);
		norm_any = |(stat1 & mask1_r & NORM1) | |(stat2 & mask2_r & NORM2);
		core.fast_request_n   = ~fast_any;
		core.normal_request_n = ~(norm_any & ~fast_any);
	end

	// write channel accepts address and data in either order
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt  = w_data_r;
		w_strb_nxt  = w_strb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		awready     = ~aw_held_r & ~bvalid_r;
		wready      = ~w_held_r & ~bvalid_r;
		if (awvalid && awready) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = awaddr;
		end
		if (wvalid && wready) begin
			w_held_nxt = 1'b1;
			w_data_nxt = wdata;
			w_strb_nxt = wstrb;
		end
		wr_go = aw_held_r & w_held_r;
		wr_hit = (aw_addr_r == OFF_MASK1) || (aw_addr_r == OFF_MASK2) || (aw_addr_r == OFF_MASK3)
			|| (aw_addr_r == OFF_EOI);
		if (wr_go) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// mask writes steer outputs; eoi latch set wins over clear
	always_comb begin
		mask1_nxt = mask1_r;
		mask2_nxt = mask2_r;
		mask3_nxt = mask3_r;
		eoi2_nxt  = eoi2_r;
		if (wr_go) begin
			if (aw_addr_r == OFF_MASK1) begin
				if (w_strb_r[0]) mask1_nxt[7:0]  = w_data_r[7:0];
				if (w_strb_r[1]) mask1_nxt[15:8] = w_data_r[15:8];
			end else if (aw_addr_r == OFF_MASK2) begin
				if (w_strb_r[0]) mask2_nxt[7:0]  = w_data_r[7:0];
				if (w_strb_r[1]) mask2_nxt[15:8] = w_data_r[15:8];
			end else if (aw_addr_r == OFF_MASK3) begin
				if (w_strb_r[0]) mask3_nxt = w_data_r[7:0];
			end else if (aw_addr_r == OFF_EOI) begin
				if (w_strb_r[0]) eoi2_nxt = eoi2_r & ~(w_data_r[15:0] & EOI2);
			end
		end
		eoi2_nxt = eoi2_nxt | (raw2 & EOI2);
	end

	// read channel, status shows all pending sources
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		arready    = ~rvalid_r;
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			if (araddr == OFF_MASK1) begin
				rdata_nxt = {16'h0000, mask1_r};
			end else if (araddr == OFF_STAT1) begin
				rdata_nxt = {16'h0000, stat1};
			end else if (araddr == OFF_MASK2) begin
				rdata_nxt = {16'h0000, mask2_r};
			end else if (araddr == OFF_STAT2) begin
				rdata_nxt = {16'h0000, stat2};
			end else if (araddr == OFF_MASK3) begin
				rdata_nxt = {24'h000000, mask3_r};
			end else if (araddr == OFF_STAT3) begin
				rdata_nxt = {24'h000000, stat3};
			end else if (araddr == OFF_EOI) begin
				rdata_nxt = {16'h0000, eoi2_r};
			end else begin
				rdata_nxt = 32'h00000000;
				rresp_nxt = RESP_SLVERR;
			end
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 5'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= RESP_OKAY;
			mask1_r   <= MASK1_RST;
			mask2_r   <= MASK2_RST;
			mask3_r   <= MASK3_RST;
			eoi2_r    <= 16'h0000;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r  <= w_data_nxt;
			w_strb_r  <= w_strb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			mask1_r   <= mask1_nxt;
			mask2_r   <= mask2_nxt;
			mask3_r   <= mask3_nxt;
			eoi2_r    <= eoi2_nxt;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp  = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata  = rdata_r;
	assign rresp  = rresp_r;

	// checks
	AST_FAST_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
		core.fast_request_n == ((raw1[3:0] & mask1_r[3:0]) == 4'h0 && !(raw3[0] && mask3_r[0])))
		else $error("fast output disagrees with masked status");
	AST_FAST_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
		!core.fast_request_n |-> core.normal_request_n)
		else $error("normal asserted with fast");
	AST_NORM_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
		(core.fast_request_n && |(stat2 & mask2_r)) |-> !core.normal_request_n)
		else $error("masked normal source not on output");
	AST_MASK_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		(mask1_r == 16'h0000 && mask3_r == 8'h00) |-> core.fast_request_n)
		else $error("fast output without mask");
	AST_EOI_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(eoi2_r[1] && !(wr_go && aw_addr_r == OFF_EOI)) |=> eoi2_r[1])
		else $error("latched source dropped");
	AST_EOI_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		src.sync_two_rx_block |=> stat2[1])
		else $error("latched source not captured");
	AST_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
		stat1[4] == src.codec_sound_request)
		else $error("level source not shown directly");
	AST_PIN_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
		(!src.external_fast_pin_n [*4]) |=> stat1[0])
		else $error("fast pin not shown in status");
	AST_FILT: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(media_r) |-> $past(filt_tick))
		else $error("media status changed off tick");
	AST_RD_ANS: assert property (@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready) |=> rvalid)
		else $error("read not answered");
	sequence wr_both_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence wr_answered;
		##1 bvalid;
	endsequence
	AST_WR_ANS: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_both_taken |=> wr_answered)
		else $error("write not answered");

endmodule

// >>> rtl/tlic_pkg.sv
// package for the two-level request controller
package tlic_pkg;

	// register byte offsets
	localparam logic [4:0] OFF_MASK1 = 5'h00;
	localparam logic [4:0] OFF_STAT1 = 5'h04;
	localparam logic [4:0] OFF_MASK2 = 5'h08;
	localparam logic [4:0] OFF_STAT2 = 5'h0C;
	localparam logic [4:0] OFF_MASK3 = 5'h10;
	localparam logic [4:0] OFF_STAT3 = 5'h14;
	localparam logic [4:0] OFF_EOI   = 5'h18;

	// reset values
	localparam logic [15:0] MASK1_RST = 16'h0000;
	localparam logic [15:0] MASK2_RST = 16'h0000;
	localparam logic [7:0]  MASK3_RST = 8'h00;

	// group membership per pair, 1 = member of the named group (FAST or NORM)
	localparam logic [15:0] FAST1 = 16'h000F;
	localparam logic [15:0] NORM1 = 16'hFFF0;
	localparam logic [15:0] NORM2 = 16'h3007;
	localparam logic [7:0]  FAST3 = 8'h01;

	// latched end-of-interrupt kind sources (second pair, sync two blocks)
	localparam logic [15:0] EOI2 = 16'h0006;

	// deglitch timing: 16.384 kHz filter tick from 200 MHz
	localparam int CLK_HZ       = 200000000;
	localparam int FILT_HZ      = 16384;
	localparam int FILT_CYC     = CLK_HZ / FILT_HZ;
	localparam logic [13:0] FILT_LAST = 14'(FILT_CYC - 1);

	// bus response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        fast_request_n;
		logic        normal_request_n;
	} tlic_core_type;

	typedef struct packed {
		logic        external_fast_pin_n;
		logic        battery_low_request;
		logic        watchdog_expired_request;
		logic        media_changed_request;
		logic        codec_sound_request;
		logic        external_pin_one_n;
		logic        external_pin_two_n;
		logic        external_request_three;
		logic        timer_one_underflow;
		logic        timer_two_underflow;
		logic        clock_compare_match;
		logic        tick_request;
		logic        serial_one_tx_empty;
		logic        serial_one_rx_full;
		logic        serial_one_modem_change;
		logic        sync_one_end_transfer;
		logic        key_press_request;
		logic        sync_two_rx_block;
		logic        sync_two_tx_block;
		logic        serial_two_tx_empty;
		logic        serial_two_rx_full;
		logic        codec_port_request;
	} tlic_src_type;

endpackage

// >>> verification/tlic_core_model.sv
// processor core model sampling the two request lines
`timescale 1ns/100ps
module tlic_core_model
	import tlic_pkg::*;
(
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// request lines from the controller
	input  wire tlic_core_type core,
	// handler in service: 2 fast, 1 normal, 0 none
	output logic [1:0]         svc
);
	logic [1:0] s1_r;
	logic [1:0] s2_r;

	// two-flop synchroniser on the active-low lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= 2'h3;
			s2_r <= 2'h3;
		end else begin
			s1_r <= core;
			s2_r <= s1_r;
		end
	end

	// fast handler served before normal
	assign svc = !s2_r[1] ? 2'h2 : (!s2_r[0] ? 2'h1 : 2'h0);
endmodule

// >>> verification/tlic_top_bench.sv
// self-checking bench for the two-level request controller
`timescale 1ns/100ps
module tlic_top_bench;
	import tlic_pkg::*;
	localparam logic [21:0] IDLE = 22'h218000;
	logic          aclk;
	logic          aresetn;
	tlic_src_type  src;
	tlic_core_type core;
	logic          awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [4:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata, rnd, ev;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp, svc;
	logic [4:0]    off;
	logic [33:0]   rq[$];
	logic [1:0]    bq[$];
	int            mismatches, checks, cyc, b, n;
	bit            fast;

	tlic_top tlic_top_inst (.aclk(aclk), .aresetn(aresetn), .src(src), .core(core),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));
	tlic_core_model tlic_core_model_inst (.aclk(aclk), .aresetn(aresetn), .core(core), .svc(svc));

	always #2.5 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] st = 4'hF);
		bq.push_back(er);
		awaddr <= a;
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		rq.push_back({er, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// settled look at the core lines and the core model
	task automatic look(input logic [1:0] ec, input logic [1:0] es);
		#1;
		cmp("core", {32'h0, ec}, {32'h0, core});
		cmp("svc", {32'h0, es}, {32'h0, svc});
		@(posedge aclk);
	endtask

	// response watcher
	always @(posedge aclk) begin
		if (aresetn && rvalid && rready) cmp("read", rq.pop_front(), {rresp, rdata});
		if (aresetn && bvalid && bready) cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 70000) begin
			mismatches++;
			$display("timeout");
			wrap_up();
		end
	end

	initial begin
		aclk = 0;
		aresetn = 0;
		src = IDLE;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{mismatches, checks, cyc} = '0;
		rnd = 32'h5F;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_MASK1, {16'h0, MASK1_RST}, RESP_OKAY);
		rd(OFF_MASK2, {16'h0, MASK2_RST}, RESP_OKAY);
		rd(OFF_MASK3, {24'h0, MASK3_RST}, RESP_OKAY);
		rd(OFF_STAT1, 32'h0, RESP_OKAY);
		look(2'h3, 2'h0);
		$display("test reset done");
		// battery low and timer one together, masks still clear
		src <= IDLE | 22'h102000;
		repeat (8) @(posedge aclk);
		look(2'h3, 2'h0);
		rd(OFF_STAT1, 32'h0102, RESP_OKAY);
		wr(OFF_MASK1, 32'hFFFF, RESP_OKAY);
		wr(OFF_MASK2, {16'h0, NORM2}, RESP_OKAY);
		wr(OFF_MASK3, 32'h01, RESP_OKAY);
		repeat (4) @(posedge aclk);
		look(2'h1, 2'h2);
		src <= IDLE | 22'h002000;
		repeat (4) @(posedge aclk);
		look(2'h2, 2'h1);
		src <= IDLE;
		$display("test precedence done");
		rnd = xs(rnd);
		wr(OFF_MASK1, {16'h0, rnd[15:0]}, RESP_OKAY);
		rd(OFF_MASK1, {16'h0, rnd[15:0]}, RESP_OKAY);
		wr(OFF_MASK1, 32'hFFFF, RESP_OKAY);
		wr(OFF_MASK1, 32'h0, RESP_OKAY, 4'h2);
		rd(OFF_MASK1, 32'h00FF, RESP_OKAY);
		wr(OFF_MASK1, 32'hFFFF, RESP_OKAY);
		rd(OFF_MASK2, {16'h0, NORM2}, RESP_OKAY);
		rd(OFF_MASK3, 32'h01, RESP_OKAY);
		rd(5'h1C, 32'h0, RESP_SLVERR);
		wr(5'h1C, 32'hFFFF, RESP_SLVERR);
		$display("test registers done");
		for (int i = 0; i < 22; i++) begin
			if (i >= 6) begin
				off = OFF_STAT1;
				b = 21 - i;
			end else if (i >= 3) begin
				off = OFF_STAT2;
				b = 5 - i;
			end else if (i >= 1) begin
				off = OFF_STAT2;
				b = 14 - i;
			end else begin
				off = OFF_STAT3;
				b = 0;
			end
			fast = (i >= 18) || (i == 0);
			n = (i == 18) ? 2 * FILT_CYC + 16 : 8;
			ev = 32'h1 << b;
			src <= IDLE ^ (22'h1 << i);
			repeat (n) @(posedge aclk);
			look(fast ? 2'h1 : 2'h2, fast ? 2'h2 : 2'h1);
			rd(off, ev, RESP_OKAY);
			src <= IDLE;
			repeat (n) @(posedge aclk);
			if (i == 3 || i == 4) begin
				rd(off, ev, RESP_OKAY);
				rd(OFF_EOI, ev, RESP_OKAY);
				wr(OFF_EOI, ev, RESP_OKAY);
			end
			rd(off, 32'h0, RESP_OKAY);
			look(2'h3, 2'h0);
		end
		$display("test sources done");
		wrap_up();
	end
endmodule
